/* hdl/udh_defs.svh */
// Offsets, field positions, reset values and timing counts for the DMA handshake block.
`ifndef UDH_DEFS_SVH
`define UDH_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UDH_PINCFG_OFF 8'h0E
`define UDH_CFG0_OFF 8'h10
`define UDH_CFG1_OFF 8'h12
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UDH_DRV_BIT 15
`define UDH_IRQPOL_BIT 0
`define UDH_REQPOL_BIT 14
`define UDH_BURST_BIT 13
`define UDH_ACKPOL_BIT 10
`define UDH_FORM_HI 9
`define UDH_FORM_LO 7
`define UDH_ENDPOL_BIT 6
`define UDH_TRANSFER_END_PACKET_MODE_BIT 5
`define UDH_ENDEN_BIT 4
`define UDH_GATEDIS_BIT 2
// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define UDH_CFG_RESET 16'h0000
`define UDH_PINCFG_RESET 16'h0000
`define UDH_CFG_WMASK 16'h67F4
`define UDH_PINCFG_WMASK 16'h8001
// ----------------------------------------------------------------
// Access signal codes
// ----------------------------------------------------------------
`define UDH_FORM_ADDR 3'h0
`define UDH_FORM_ACKSTB 3'h2
`define UDH_FORM_ACKONLY 3'h3
`define UDH_FORM_SPLIT 3'h4
// ----------------------------------------------------------------
// Host timing counts in clock cycles
// ----------------------------------------------------------------
`define UDH_ACK_HOLD 4'h8
`define UDH_ACK_GAP 4'h8
`endif

/* hdl/udh_pkg.sv */
// Types shared by both ends of the DMA handshake link.
package udh_pkg;
  typedef logic [15:0] udh_reg_t;
  typedef logic [2:0] udh_pipe_t;
  typedef enum logic [1:0] {
    UDH_IDLE,
    UDH_ACK,
    UDH_GAP
  } udh_host_state_t;
endpackage

/* hdl/udh_link_if.sv */
// Pin-level link between the controller end and the external DMA controller end.
`timescale 1ns/1ps
`default_nettype none
interface udh_link_if;
  logic [1:0] dma_request_out;
  logic [1:0] dma_acknowledge_in;
  logic [1:0] end_o;
  logic [1:0] end_oe;
  logic [1:0] dma_transfer_end;
  logic [1:0][7:0] data_o;
  logic [1:0] data_oe;
  logic [1:0][7:0] split_data_bus;
  // Undriven pins read high, as an external pull-up would leave them.
  assign dma_transfer_end = (end_o & end_oe) | ~end_oe;
  assign split_data_bus[0] = data_oe[0] ? data_o[0] : 8'hFF;
  assign split_data_bus[1] = data_oe[1] ? data_o[1] : 8'hFF;
  modport dev (
    output dma_request_out,
    input dma_acknowledge_in,
    output end_o,
    output end_oe,
    output data_o,
    output data_oe
  );
  modport host (
    input dma_request_out,
    output dma_acknowledge_in,
    input dma_transfer_end,
    input split_data_bus
  );
endinterface
`default_nettype wire

/* hdl/udh_dev.sv */
// Controller end of the DMA handshake: configuration registers, request, acknowledge, end and FIFO.
//
// Contract
// [R1] Software sets drive strength once after reset.
// [R2] Interrupt output follows selected polarity.
// [R3] Request pin polarity from bit 14.
// [R4] Bit 13 picks cycle-steal or burst.
// [R5] Cycle-steal drops request after each access.
// [R6] Burst drops request on final buffer word.
// [R7] Software keeps burst bit fixed during transfers.
// [R8] Acknowledge input polarity from bit 10.
// [R9] Bits 9-7 choose the access signal set.
// [R10] Transfer-end pin polarity from bit 6.
// [R11] Packet mode 0: short, count-done, empty ZLP.
// [R12] Packet mode 1: end per full buffer.
// [R13] Bit 4 enables the transfer-end pin.
// [R14] Bit 2 set disables output-bus gating.
// [R15] Ready buffer plus enable raises the request.
// [R16] Handshake applies only to the selected pipe.
// [R17] Software changes polarities only with pipe zero.
// [R18] Two independent channel configuration registers.
// [R19] Software writes zero to unassigned bits.
// [R20] Gating off drives pins only during acknowledge.
// [R21] Request returns while buffer stays ready.
`timescale 1ns/1ps
`default_nettype none
`include "udh_defs.svh"

module udh_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;
  logic [AW:0] count_d;
  logic ready_q;
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_out = ready_q;
  assign out_valid_out = (count_q != '0);
  assign out_data_out = mem_q[rd_q];
  assign push = ce_in & in_valid_in & in_ready_out;
  assign pop = ce_in & out_ready_in & out_valid_out;
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_d;
      ready_q <= (count_d != (AW+1)'(DEPTH));
    end
  end
endmodule

module udh_dev #(
  parameter int DATA_W = 8,
  parameter int FIFO_DEPTH = 4,
  parameter int CNT_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  udh_link_if.dev link,
  input wire logic [7:0] cpu_addr_in,
  input wire logic [15:0] cpu_wdata_in,
  input wire logic cpu_wr_in,
  input wire logic cpu_rd_in,
  output logic [15:0] cpu_rdata_out,
  input wire logic irq_event_in,
  output logic irq_out,
  output logic output_drive_select_out,
  input wire udh_pkg::udh_pipe_t [1:0] selected_pipe_field_in,
  input wire logic [1:0] buffer_ready_state_in,
  input wire logic [1:0] request_enable_in,
  input wire logic [1:0][CNT_W-1:0] buf_size_in,
  input wire logic [1:0][DATA_W-1:0] buf_data_in,
  input wire logic [1:0] buf_last_in,
  input wire logic [1:0] buf_end_in,
  input wire logic [1:0] buf_valid_in,
  output logic [1:0] buf_ready_out,
  input wire logic [1:0] zlp_empty_in
);
  import udh_pkg::*;
  localparam int FW = DATA_W + 2;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  udh_reg_t pincfg_q;
  udh_reg_t cfg_q [2];
  logic sel_pincfg;
  logic sel_cfg0;
  logic sel_cfg1;
  udh_reg_t rd_mux;
  assign sel_pincfg = (cpu_addr_in == `UDH_PINCFG_OFF);
  assign sel_cfg0 = (cpu_addr_in == `UDH_CFG0_OFF);
  assign sel_cfg1 = (cpu_addr_in == `UDH_CFG1_OFF);
  assign rd_mux = sel_pincfg ? pincfg_q :
                  sel_cfg0 ? cfg_q[0] :
                  sel_cfg1 ? cfg_q[1] : 16'h0000;

  // Unassigned bits are masked so they always read back as zero. [R19]
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pincfg_q <= `UDH_PINCFG_RESET;
      cfg_q[0] <= `UDH_CFG_RESET;
      cfg_q[1] <= `UDH_CFG_RESET;
      cpu_rdata_out <= 16'h0000;
    end else if (ce_in) begin
      if (cpu_wr_in && sel_pincfg) begin
        pincfg_q <= cpu_wdata_in & `UDH_PINCFG_WMASK; // [R1]
      end
      if (cpu_wr_in && sel_cfg0) begin
        cfg_q[0] <= cpu_wdata_in & `UDH_CFG_WMASK; // [R18]
      end
      if (cpu_wr_in && sel_cfg1) begin
        cfg_q[1] <= cpu_wdata_in & `UDH_CFG_WMASK; // [R18]
      end
      if (cpu_rd_in) begin
        cpu_rdata_out <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and drive select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b1;
      output_drive_select_out <= 1'b0;
    end else if (ce_in) begin
      irq_out <= irq_event_in ^ ~pincfg_q[`UDH_IRQPOL_BIT]; // [R2]
      output_drive_select_out <= pincfg_q[`UDH_DRV_BIT]; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Per-channel handshake
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    udh_reg_t cfg;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_prev_q;
    logic ack_act;
    logic access;
    logic sel_ok;
    logic [FW-1:0] f_data;
    logic f_valid;
    logic f_ready;
    logic f_last;
    logic f_end;
    logic want;
    logic burst;
    logic req_q;
    logic req_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_inc;
    logic full_buf;
    logic end_evt;
    logic end_act_q;
    logic [2:0] form;
    logic form_ok;
    logic gate_ok;
    logic req_pin_q;
    logic end_o_q;
    logic end_oe_q;
    logic [DATA_W-1:0] data_q;
    logic data_oe_q;

    assign cfg = cfg_q[g];
    assign burst = cfg[`UDH_BURST_BIT]; // [R4]
    assign form = cfg[`UDH_FORM_HI:`UDH_FORM_LO];
    assign ack_act = ack_s2_q ^ ~cfg[`UDH_ACKPOL_BIT]; // [R8]
    assign access = ack_act & ~ack_prev_q & sel_ok & form_ok;
    assign sel_ok = (selected_pipe_field_in[g] != 3'h0); // [R16]
    assign form_ok = (form == `UDH_FORM_ADDR) | (form == `UDH_FORM_ACKSTB) |
                     (form == `UDH_FORM_ACKONLY) | (form == `UDH_FORM_SPLIT); // [R9]
    assign f_ready = access;
    assign f_last = f_data[DATA_W];
    assign f_end = f_data[DATA_W+1];
    assign want = sel_ok & form_ok & buffer_ready_state_in[g] & request_enable_in[g] & f_valid;
    assign cnt_inc = cnt_q + 1'b1;
    assign full_buf = (cnt_inc == buf_size_in[g]);
    assign end_evt = cfg[`UDH_TRANSFER_END_PACKET_MODE_BIT] ? (access & full_buf) : // [R12]
                     ((access & f_end) | (zlp_empty_in[g] & ~f_valid & sel_ok)); // [R11]
    // With gating disabled the split pins only drive during acknowledge. [R20]
    assign gate_ok = cfg[`UDH_GATEDIS_BIT] ? ack_act : 1'b1; // [R14]

    // A cycle-steal access always drops the request; a burst keeps it up until
    // the buffer's final word, then the request follows buffer readiness again.
    always_comb begin
      req_d = req_q;
      if (access) begin
        req_d = burst & ~f_last & want; // [R5] [R6]
      end else if (!ack_act) begin
        req_d = want; // [R15] [R21]
      end
    end

    udh_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
    ) u_fifo (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .ce_in(ce_in),
      .in_data_in({buf_end_in[g], buf_last_in[g], buf_data_in[g]}),
      .in_valid_in(buf_valid_in[g]),
      .in_ready_out(buf_ready_out[g]),
      .out_data_out(f_data),
      .out_valid_out(f_valid),
      .out_ready_in(f_ready)
    );

    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        ack_s1_q <= 1'b1;
        ack_s2_q <= 1'b1;
        ack_prev_q <= 1'b0;
        req_q <= 1'b0;
        cnt_q <= '0;
        end_act_q <= 1'b0;
      end else if (ce_in) begin
        ack_s1_q <= link.dma_acknowledge_in[g];
        ack_s2_q <= ack_s1_q;
        ack_prev_q <= ack_act;
        req_q <= req_d;
        if (access) begin
          cnt_q <= full_buf ? '0 : cnt_inc; // [R12]
        end
        end_act_q <= end_evt | (end_act_q & ack_act);
      end
    end

    // Pin registers: the request reflects the new state in the same edge.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        req_pin_q <= 1'b1;
        end_o_q <= 1'b1;
        end_oe_q <= 1'b0;
        data_q <= '0;
        data_oe_q <= 1'b0;
      end else if (ce_in) begin
        req_pin_q <= req_d ^ ~cfg[`UDH_REQPOL_BIT]; // [R3]
        end_o_q <= (end_evt | (end_act_q & ack_act)) ^ ~cfg[`UDH_ENDPOL_BIT]; // [R10]
        end_oe_q <= cfg[`UDH_ENDEN_BIT] & gate_ok & sel_ok; // [R13]
        if (access) begin
          data_q <= f_data[DATA_W-1:0];
        end
        data_oe_q <= sel_ok & ((form == `UDH_FORM_SPLIT) ? gate_ok : // [R9] [R20]
                     (form_ok & ack_act));
      end
    end

    assign link.dma_request_out[g] = req_pin_q;
    assign link.end_o[g] = end_o_q;
    assign link.end_oe[g] = end_oe_q;
    assign link.data_o[g] = data_q;
    assign link.data_oe[g] = data_oe_q;
  end
endmodule
`default_nettype wire

/* hdl/udh_host.sv */
// External DMA controller end: answers requests with acknowledge cycles and collects data.
`timescale 1ns/1ps
`default_nettype none
`include "udh_defs.svh"

module udh_host #(
  parameter int DATA_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  udh_link_if.host link,
  input wire logic [1:0] chan_enable_in,
  input wire logic [1:0] request_polarity_in,
  input wire logic [1:0] acknowledge_polarity_in,
  input wire logic [1:0] transfer_end_polarity_in,
  output logic [1:0][DATA_W-1:0] word_data_out,
  output logic [1:0] word_end_out,
  output logic [1:0] word_valid_out
);
  import udh_pkg::*;

  // ----------------------------------------------------------------
  // Per-channel acknowledge sequencer
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_ch
    udh_host_state_t state_q;
    logic [3:0] cnt_q;
    logic req_s1_q;
    logic req_s2_q;
    logic end_s1_q;
    logic end_s2_q;
    logic [DATA_W-1:0] dat_s1_q;
    logic [DATA_W-1:0] dat_s2_q;
    logic req_act;
    logic end_act;
    logic end_seen_q;
    logic ack_pin_q;
    logic hold_done;
    logic gap_done;

    // The gap lets the request change travel through both synchronisers
    // before it is sampled again, so a dropped request is not re-acknowledged.
    assign req_act = req_s2_q ^ ~request_polarity_in[g]; // [R3]
    assign end_act = end_s2_q ^ ~transfer_end_polarity_in[g]; // [R10]
    assign hold_done = (cnt_q == `UDH_ACK_HOLD - 4'h1);
    assign gap_done = (cnt_q == `UDH_ACK_GAP - 4'h1);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        req_s1_q <= 1'b0;
        req_s2_q <= 1'b0;
        end_s1_q <= 1'b1;
        end_s2_q <= 1'b1;
        dat_s1_q <= '0;
        dat_s2_q <= '0;
      end else if (ce_in) begin
        req_s1_q <= link.dma_request_out[g];
        req_s2_q <= req_s1_q;
        end_s1_q <= link.dma_transfer_end[g];
        end_s2_q <= end_s1_q;
        dat_s1_q <= link.split_data_bus[g];
        dat_s2_q <= dat_s1_q;
      end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        state_q <= UDH_IDLE;
        cnt_q <= 4'h0;
        end_seen_q <= 1'b0;
        ack_pin_q <= 1'b1;
        word_data_out[g] <= '0;
        word_end_out[g] <= 1'b0;
        word_valid_out[g] <= 1'b0;
      end else if (ce_in) begin
        word_valid_out[g] <= 1'b0;
        ack_pin_q <= ~acknowledge_polarity_in[g]; // [R8]
        case (state_q)
          UDH_IDLE: begin
            cnt_q <= 4'h0;
            end_seen_q <= 1'b0;
            if (chan_enable_in[g] && req_act) begin
              state_q <= UDH_ACK;
              ack_pin_q <= acknowledge_polarity_in[g]; // [R8]
            end
          end
          UDH_ACK: begin
            cnt_q <= cnt_q + 4'h1;
            end_seen_q <= end_seen_q | end_act;
            if (hold_done) begin
              state_q <= UDH_GAP;
              cnt_q <= 4'h0;
              word_data_out[g] <= dat_s2_q;
              word_end_out[g] <= end_seen_q | end_act;
              word_valid_out[g] <= 1'b1;
            end else begin
              ack_pin_q <= acknowledge_polarity_in[g];
            end
          end
          UDH_GAP: begin
            cnt_q <= cnt_q + 4'h1;
            if (gap_done) begin
              state_q <= UDH_IDLE;
            end
          end
          default: begin
            state_q <= UDH_IDLE;
          end
        endcase
      end
    end

    assign link.dma_acknowledge_in[g] = ack_pin_q;
  end
endmodule
`default_nettype wire

/* bench/udh_link_asserts.sv */
// Concurrent checks on the pins between the controller end and the DMA controller end.
`timescale 1ns/1ps
`default_nettype none
module udh_link_asserts #(
  parameter logic [1:0] ACT_POL = 2'b01
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] dma_request_out,
  input wire logic [1:0] dma_acknowledge_in,
  input wire logic [1:0] end_o,
  input wire logic [1:0] end_oe,
  input wire logic [1:0] data_oe
);
  // ----------------------------------------------------------------
  // Active levels
  // ----------------------------------------------------------------
  // Polarity is fixed per channel by the bench, so it comes in as a parameter.
  logic [1:0] req_act;
  logic [1:0] ack_act;
  logic [1:0] end_act;
  assign req_act = ~(dma_request_out ^ ACT_POL);
  assign ack_act = ~(dma_acknowledge_in ^ ACT_POL);
  assign end_act = end_oe & ~(end_o ^ ACT_POL);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  reset_idle_a: assert property ($rose(reset_n_in) |->
    end_oe == 2'b00 && data_oe == 2'b00 && dma_request_out == 2'b11)
    else $error("pins not idle after reset");
  ack_hold_a: assert property ($rose(ack_act[0]) |=> ack_act[0] [*6])
    else $error("acknowledge dropped early");
  ack_gap_a: assert property ($fell(ack_act[1]) |=> (!ack_act[1]) [*6])
    else $error("acknowledge gap too short");
  cs_negate_a: assert property ($rose(ack_act[0]) |-> ##[1:4] !req_act[0])
    else $error("request kept after single access");
  burst_drop_a: assert property ($fell(req_act[1]) |-> ack_act[1])
    else $error("burst request dropped outside an access");
  end_window_a: assert property (end_act[1] |-> ack_act[1] || $past(ack_act[1]) ||
    $past(ack_act[1], 2) || $past(ack_act[1], 3) || $past(ack_act[1], 4))
    else $error("transfer end outside an access");
  data_drive_a: assert property (data_oe[1] |-> ack_act[1] || $past(ack_act[1]) ||
    $past(ack_act[1], 2) || $past(ack_act[1], 3) || $past(ack_act[1], 4))
    else $error("data driven without acknowledge");
  req_ack_a: assert property ($rose(ack_act[1]) |-> $past(req_act[1], 2) ||
    $past(req_act[1], 3) || $past(req_act[1], 4))
    else $error("acknowledge without request");
endmodule
`default_nettype wire

/* bench/dma_handshake_pin_config_tb.sv */
// Self-checking bench joining both ends of the DMA handshake link.
`timescale 1ns/1ps
`default_nettype none
module dma_handshake_pin_config_tb;
  import udh_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ce = 1'b1;
  logic [7:0] cpu_addr_in = 8'h00;
  logic [15:0] cpu_wdata_in = 16'h0000;
  logic cpu_wr_in = 1'b0;
  logic cpu_rd_in = 1'b0;
  logic irq_event_in = 1'b0;
  logic [15:0] cpu_rdata_out;
  logic irq_out;
  logic drv_sel;
  udh_pipe_t [1:0] pipe_sel = '0;
  logic [1:0] buf_rdy = 2'b00;
  logic [1:0] req_en = 2'b00;
  logic [1:0] buf_last = 2'b00;
  logic [1:0] buf_end = 2'b00;
  logic [1:0] buf_valid = 2'b00;
  logic [1:0] zlp = 2'b00;
  logic [1:0] chan_en = 2'b00;
  logic [1:0] buf_ready;
  logic [1:0] word_end;
  logic [1:0] word_valid;
  logic [1:0][11:0] buf_size = {12'h004, 12'h000};
  logic [1:0][7:0] buf_data = '0;
  logic [1:0][7:0] word_data;
  logic [7:0] dat [2][8];
  logic [2:0] rsv [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
  logic [15:0] r;
  int rx [2] = '{0, 0};
  int error_cnt = 0;
  int n_compared = 0;
  udh_link_if link ();
  udh_dev udh_dev_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce), .link(link.dev),
    .cpu_addr_in(cpu_addr_in), .cpu_wdata_in(cpu_wdata_in), .cpu_wr_in(cpu_wr_in),
    .cpu_rd_in(cpu_rd_in), .cpu_rdata_out(cpu_rdata_out), .irq_event_in(irq_event_in),
    .irq_out(irq_out), .output_drive_select_out(drv_sel), .selected_pipe_field_in(pipe_sel),
    .buffer_ready_state_in(buf_rdy), .request_enable_in(req_en), .buf_size_in(buf_size),
    .buf_data_in(buf_data), .buf_last_in(buf_last), .buf_end_in(buf_end),
    .buf_valid_in(buf_valid), .buf_ready_out(buf_ready), .zlp_empty_in(zlp));
  udh_host udh_host_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
    .link(link.host), .chan_enable_in(chan_en), .request_polarity_in(2'b01),
    .acknowledge_polarity_in(2'b01), .transfer_end_polarity_in(2'b01),
    .word_data_out(word_data), .word_end_out(word_end), .word_valid_out(word_valid));
  udh_link_asserts #(.ACT_POL(2'b01)) udh_link_asserts_i (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .dma_request_out(link.dma_request_out),
    .dma_acknowledge_in(link.dma_acknowledge_in), .end_o(link.end_o),
    .end_oe(link.end_oe), .data_oe(link.data_oe));
  always #20 clk_in = ~clk_in;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic end_want(int c, int n);
    return (c == 1) ? (n % 4 == 3) : (n == 3);
  endfunction
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_wr_in = 1'b1;
    step(1);
    cpu_wr_in = 1'b0;
    step(1);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] exp, string name);
    cpu_addr_in = a;
    cpu_rd_in = 1'b1;
    step(1);
    cpu_rd_in = 1'b0;
    chk(name, cpu_rdata_out, exp);
    step(1);
  endtask
  // A full FIFO holds the word up, so the wait is bounded to avoid a silent hang.
  task automatic push(int c, logic [7:0] d, logic l, logic e);
    buf_data[c] = d;
    buf_last[c] = l;
    buf_end[c] = e;
    buf_valid[c] = 1'b1;
    for (int k = 0; k < 2000 && buf_ready[c] !== 1'b1; k++) step(1);
    step(1);
    buf_valid[c] = 1'b0;
    step(1);
  endtask
  task automatic wait_rx(int c, int n);
    for (int k = 0; k < 3000 && rx[c] < n; k++) step(1);
    chk("word count", 16'(rx[c]), 16'(n));
  endtask
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    for (int c = 0; c < 2; c++) begin
      if (word_valid[c] === 1'b1) begin
        chk("word data", {8'h00, word_data[c]}, {8'h00, dat[c][rx[c] % 8]});
        chk("word end", {15'h0, word_end[c]}, {15'h0, end_want(c, rx[c])});
        rx[c]++;
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    results();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h63306ad4));
    step(16);
    reset_n_in = 1'b1;
    step(1);
    rd(8'h10, 16'h0000, "cfg0 reset");
    rd(8'h12, 16'h0000, "cfg1 reset");
    rd(8'h0E, 16'h0000, "pincfg reset");
    ce = 1'b0;
    wr(8'h12, 16'h2000);
    ce = 1'b1;
    rd(8'h12, 16'h0000, "ce freeze");
    chk("req idle", {14'h0, link.dma_request_out}, 16'h0003);
    wr(8'h10, 16'hFFFF);
    rd(8'h10, 16'h67F4, "cfg0 mask");
    rd(8'h12, 16'h0000, "cfg1 apart");
    wr(8'h40, 16'($urandom));
    rd(8'h40, 16'h0000, "unmapped");
    wr(8'h0E, 16'hFFFF);
    rd(8'h0E, 16'h8001, "pincfg mask");
    chk("drive select", {15'h0, drv_sel}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom);
      irq_event_in = r[0];
      wr(8'h0E, {1'b1, 14'h0, r[1]});
      step(2);
      chk("irq level", {15'h0, irq_out}, {15'h0, r[0] ~^ r[1]});
    end
    wr(8'h10, 16'h4650);
    wr(8'h12, 16'h21B4);
    chan_en = 2'b11;
    step(1);
    chk("req polarity", {14'h0, link.dma_request_out}, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom);
      dat[0][i] = r[7:0];
      push(0, r[7:0], i == 3, i == 3);
    end
    chk("fifo full", {15'h0, buf_ready[0]}, 16'h0000);
    buf_rdy = 2'b11;
    req_en = 2'b11;
    for (int i = 0; i < 4; i++) begin
      pipe_sel[0] = 3'h0;
      wr(8'h10, 16'h4450 | {6'h00, rsv[i], 7'h00});
      pipe_sel[0] = 3'h1;
      step(10);
      chk("reserved form", {15'h0, link.dma_request_out[0]}, 16'h0000);
    end
    pipe_sel[0] = 3'h0;
    wr(8'h10, 16'h4650);
    step(10);
    chk("pipe zero", {15'h0, link.dma_request_out[0]}, 16'h0000);
    pipe_sel[0] = 3'h1;
    wait_rx(0, 4);
    step(8);
    chk("gating on", {15'h0, link.data_oe[0]}, 16'h0001);
    chk("end idle", {15'h0, link.dma_transfer_end[0]}, 16'h0000);
    zlp[0] = 1'b1;
    step(1);
    zlp[0] = 1'b0;
    for (int k = 0; k < 8 && link.end_o[0] !== 1'b1; k++) step(1);
    chk("zero length end", {15'h0, link.end_o[0]}, 16'h0001);
    pipe_sel[1] = 3'h2;
    for (int i = 0; i < 8; i++) begin
      r = 16'($urandom);
      dat[1][i] = r[7:0];
      push(1, r[7:0], i % 4 == 3, 1'b0);
    end
    wait_rx(1, 8);
    step(8);
    chk("split idle", {15'h0, link.data_oe[1]}, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
